// ===== cam_pkg.sv
package cam_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned REF_PWRUP_US = 4400;
  localparam int unsigned REF_PWRUP_CYC = (REF_PWRUP_US * (CLK_HZ / 1000000));

  // ----------------------------------------------------------------
  // register map (word offsets as byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLE = 8'h10;
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h40;

  // first_config_byte fields
  localparam int unsigned CFG_SPEED_BIT = 0;
  localparam int unsigned CFG_REFERENCE_KEEP_ON_BIT_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // command fields
  localparam int unsigned CMD_MODE_LO = 0;
  localparam int unsigned CMD_KIND_BIT = 2;

  // ----------------------------------------------------------------
  // converter plan
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CELLS = 12;
  localparam int unsigned CELLS_PER_CONV = 6;
  localparam int unsigned NUM_AUX = 6;
  localparam int unsigned NUM_RES = NUM_CELLS + NUM_AUX;
  localparam int unsigned CAL_CYC = 4;
  // cycles per sample in each mode; fast is short, filtered is long
  localparam logic [15:0] OSR_27K = 16'h0010;
  localparam logic [15:0] OSR_14K = 16'h0020;
  localparam logic [15:0] OSR_7K = 16'h0040;
  localparam logic [15:0] OSR_3K = 16'h0080;
  localparam logic [15:0] OSR_2K = 16'h0100;
  localparam logic [15:0] OSR_26 = 16'h4000;
  localparam logic [31:0] SAMPLE_SIGN = 32'h8000_0000;
  localparam logic [15:0] RESULT_MAX = 16'hFFFF;
  localparam logic [15:0] RESULT_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    CAM_MODE_27K = 3'h0,
    CAM_MODE_14K = 3'h1,
    CAM_MODE_7K = 3'h2,
    CAM_MODE_3K = 3'h3,
    CAM_MODE_2K = 3'h4,
    CAM_MODE_26 = 3'h5
  } cam_mode_t;

  // core state, gray coded along standby->pwrup->measure->cal->ready
  typedef enum logic [2:0] {
    CAM_ST_STANDBY = 3'b000,
    CAM_ST_PWRUP = 3'b001,
    CAM_ST_MEASURE = 3'b011,
    CAM_ST_CAL = 3'b010,
    CAM_ST_READY = 3'b110
  } cam_state_t;

endpackage

// ===== cam_mode_lut.sv
`timescale 1ns/10ps
module cam_mode_lut
  import cam_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // selection
  input wire logic i_speed_option_bit,
  input wire logic [1:0] i_conversion_mode_field,
  // decoded mode
  output cam_mode_t o_mode,
  output logic [15:0] o_osr_cycles
);

  cam_mode_t mode_nxt;
  logic [15:0] osr_nxt;

  // ----------------------------------------------------------------
  // option bit picks the variant of all four mode field values
  // ----------------------------------------------------------------
  always_comb begin
    unique case (i_conversion_mode_field)
      2'h0: mode_nxt = i_speed_option_bit ? CAM_MODE_14K : CAM_MODE_3K;
      2'h1: mode_nxt = i_speed_option_bit ? CAM_MODE_14K : CAM_MODE_27K;
      2'h2: mode_nxt = i_speed_option_bit ? CAM_MODE_3K : CAM_MODE_7K;
      2'h3: mode_nxt = i_speed_option_bit ? CAM_MODE_2K : CAM_MODE_26;
    endcase
  end

  // cycles per sample; fast is short, filtered is long
  always_comb begin
    unique case (mode_nxt)
      CAM_MODE_27K: osr_nxt = OSR_27K;
      CAM_MODE_14K: osr_nxt = OSR_14K;
      CAM_MODE_7K: osr_nxt = OSR_7K;
      CAM_MODE_3K: osr_nxt = OSR_3K;
      CAM_MODE_2K: osr_nxt = OSR_2K;
      default: osr_nxt = OSR_26;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mode <= CAM_MODE_7K;
      o_osr_cycles <= OSR_7K;
    end else begin
      o_mode <= mode_nxt;
      o_osr_cycles <= osr_nxt;
    end
  end

endmodule

// ===== cam_core.sv
`timescale 1ns/10ps
module cam_core
  import cam_pkg::*;
#(
  parameter int unsigned REF_WAIT = REF_PWRUP_CYC
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // converter sample inputs, signed, 100 uV per step
  input wire logic signed [31:0] i_lower_sample,
  input wire logic signed [31:0] i_upper_sample,
  // status
  output logic o_busy,
  output logic o_ref_on,
  output logic o_lower_en,
  output logic o_upper_en
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cam_state_t state_r;
  cam_state_t state_nxt;
  logic [7:0] cfg_r;
  logic [2:0] cmd_r;
  logic cmd_go;
  logic aux_r;
  logic [31:0] wait_r;
  logic [15:0] tick_r;
  logic [3:0] chan_r;
  logic [15:0] res_r [NUM_RES];
  logic done_r;
  cam_mode_t mode;
  logic [15:0] osr_cycles;
  logic step_done;
  logic [15:0] lower_code;
  logic [15:0] upper_code;
  logic [4:0] rd_idx;
  logic [3:0] chan_last;
  logic cmd_take;
  logic [2:0] cmd_nxt;
  logic aux_nxt;
  logic conv_nxt;
  logic res_hit;
  logic [31:0] rdata_nxt;

  assign cmd_go = i_wr && (i_addr == ADDR_CMD);
  assign chan_last = aux_r ? 4'(NUM_AUX - 1) : 4'(CELLS_PER_CONV - 1);
  // shift before the cast so result words past the eighth keep their index
  assign rd_idx = 5'((i_addr - ADDR_RESULT_BASE) >> 2);

  // ----------------------------------------------------------------
  // command as it stands after this edge
  // ----------------------------------------------------------------
  // decoding the incoming word, not the stored one, lets a warm start
  // open its first sample window and converter enables on the new command
  assign cmd_take = cmd_go && !o_busy;
  assign cmd_nxt = cmd_take ? i_wdata[CMD_KIND_BIT:CMD_MODE_LO] : cmd_r;
  assign aux_nxt = cmd_take ? i_wdata[CMD_KIND_BIT] : aux_r;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  cam_mode_lut cam_mode_lut_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_speed_option_bit(cfg_r[CFG_SPEED_BIT]),
    .i_conversion_mode_field(cmd_nxt[CMD_MODE_LO +: 2]),
    .o_mode(mode),
    .o_osr_cycles(osr_cycles)
  );

  // ----------------------------------------------------------------
  // configuration and command capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r <= CFG_RESET;
    end else if (i_wr && i_addr == ADDR_CFG) begin
      cfg_r <= i_wdata[7:0];
    end
  end

  // a command while busy is ignored so the running sequence stays consistent
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_r <= 3'h0;
      aux_r <= 1'b0;
    end else if (cmd_take) begin
      cmd_r <= cmd_nxt;
      aux_r <= aux_nxt;
    end
  end

  // ----------------------------------------------------------------
  // core state machine
  // ----------------------------------------------------------------
  assign step_done = (tick_r >= osr_cycles - 16'h0001);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CAM_ST_STANDBY: begin
        if (cmd_go || cfg_r[CFG_REFERENCE_KEEP_ON_BIT_BIT]) begin
          state_nxt = CAM_ST_PWRUP;
        end
      end
      CAM_ST_PWRUP: begin
        if (wait_r >= REF_WAIT - 1) begin
          // a command landing in the last wait cycle must not be stranded in ready
          if (o_busy || cmd_take) begin
            state_nxt = CAM_ST_MEASURE;
          end else begin
            state_nxt = CAM_ST_READY;
          end
        end
      end
      CAM_ST_READY: begin
        if (cmd_go) begin
          state_nxt = CAM_ST_MEASURE;
        end else if (!cfg_r[CFG_REFERENCE_KEEP_ON_BIT_BIT]) begin
          state_nxt = CAM_ST_STANDBY;
        end
      end
      CAM_ST_MEASURE: begin
        if (step_done && chan_r == chan_last) begin
          state_nxt = CAM_ST_CAL;
        end
      end
      CAM_ST_CAL: begin
        if (tick_r == 16'(CAL_CYC - 1) && chan_r == chan_last) begin
          state_nxt = cfg_r[CFG_REFERENCE_KEEP_ON_BIT_BIT] ? CAM_ST_READY : CAM_ST_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= CAM_ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pending conversion flag, set by a command, cleared once calibrated
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else if (cmd_go && !o_busy) begin
      o_busy <= 1'b1;
    end else if (state_r == CAM_ST_CAL && state_nxt != CAM_ST_CAL) begin
      o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_r <= 1'b0;
    end else if (cmd_go && !o_busy) begin
      done_r <= 1'b0;
    end else if (state_r == CAM_ST_CAL && state_nxt != CAM_ST_CAL) begin
      done_r <= 1'b1;
    end
  end

  // reference power-up counter
  always_ff @(posedge i_clk) begin
    if (i_rst || state_r != CAM_ST_PWRUP) begin
      wait_r <= 32'h0;
    end else begin
      wait_r <= wait_r + 32'h1;
    end
  end

  // sample and calibration step counter, plus channel index
  always_ff @(posedge i_clk) begin
    if (i_rst || state_r != state_nxt) begin
      tick_r <= 16'h0;
      chan_r <= 4'h0;
    end else if (state_r == CAM_ST_MEASURE) begin
      tick_r <= step_done ? 16'h0 : tick_r + 16'h1;
      chan_r <= step_done ? chan_r + 4'h1 : chan_r;
    end else if (state_r == CAM_ST_CAL) begin
      tick_r <= (tick_r == 16'(CAL_CYC - 1)) ? 16'h0 : tick_r + 16'h1;
      chan_r <= (tick_r == 16'(CAL_CYC - 1)) ? chan_r + 4'h1 : chan_r;
    end
  end

  // ----------------------------------------------------------------
  // result encoding: clamp below zero and above full scale
  // ----------------------------------------------------------------
  function automatic logic [15:0] cam_clamp(input logic signed [31:0] s);
    logic [15:0] r;
    r = s[15:0];
    if ((s & SAMPLE_SIGN) != 32'h0) begin
      r = RESULT_ZERO;
    end else if (s[31:16] != 16'h0) begin
      r = RESULT_MAX;
    end
    return r;
  endfunction

  // one encoder per converter so cell and aux words read alike
  assign lower_code = cam_clamp(i_lower_sample);
  assign upper_code = cam_clamp(i_upper_sample);

  // each channel result is stored at the end of its sample window
  always_ff @(posedge i_clk) begin
    if (state_r == CAM_ST_MEASURE && step_done) begin
      if (aux_r) begin
        res_r[5'(NUM_CELLS) + 5'(chan_r)] <= lower_code;
      end else begin
        res_r[5'(chan_r)] <= lower_code;
        res_r[5'(chan_r) + 5'(CELLS_PER_CONV)] <= upper_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // converter enables and reference
  // ----------------------------------------------------------------
  // decoded once so both converters agree on the phase
  assign conv_nxt = (state_nxt == CAM_ST_MEASURE) || (state_nxt == CAM_ST_CAL);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_lower_en <= 1'b0;
      o_upper_en <= 1'b0;
      o_ref_on <= 1'b0;
    end else begin
      o_lower_en <= conv_nxt;
      o_upper_en <= conv_nxt && !aux_nxt;
      o_ref_on <= (state_nxt != CAM_ST_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // register read, data one cycle after the strobe
  // ----------------------------------------------------------------
  // idle cycles and unmapped addresses read as zero, so several slaves
  // can share one or-ed return bus
  assign res_hit = (i_addr >= ADDR_RESULT_BASE) &&
                   (i_addr < ADDR_RESULT_BASE + 8'(NUM_RES * 4));

  always_comb begin
    rdata_nxt = 32'h0;
    if (i_rd) begin
      if (i_addr == ADDR_CFG) begin
        rdata_nxt = {24'h0, cfg_r};
      end else if (i_addr == ADDR_CMD) begin
        rdata_nxt = {29'h0, aux_r, cmd_r[1:0]};
      end else if (i_addr == ADDR_STATUS) begin
        rdata_nxt = {24'h0, 1'b0, mode, state_r, done_r};
      end else if (res_hit) begin
        rdata_nxt = {16'h0, res_r[rd_idx]};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

endmodule

// ===== cam_core_sva.sv
`timescale 1ns/10ps
// --------------------------------
// core port checker
// --------------------------------
module cam_core_sva
  import cam_pkg::*;
#(
  parameter int unsigned REF_WAIT = 20
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // status
  input wire logic o_busy,
  input wire logic o_ref_on,
  input wire logic o_lower_en,
  input wire logic o_upper_en
);
  logic keep_r;
  logic [15:0] up_cnt_r;
  logic cmd_w;
  assign cmd_w = i_wr && (i_addr == ADDR_CMD) && !o_busy;
  // mirror of the keep-on bit as last written
  always_ff @(posedge i_clk) begin
    if (i_rst)
      keep_r <= 1'b0;
    else if (i_wr && (i_addr == ADDR_CFG))
      keep_r <= i_wdata[CFG_REFERENCE_KEEP_ON_BIT_BIT];
  end
  // cycles the reference has been up; saturates so it never wraps
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_ref_on)
      up_cnt_r <= 16'h0000;
    else if (up_cnt_r != 16'hFFFF)
      up_cnt_r <= up_cnt_r + 16'h0001;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence cmd_s;
    cmd_w;
  endsequence
  sequence warm_cmd_s;
    cmd_s ##0 (keep_r && int'(up_cnt_r) >= REF_WAIT);
  endsequence
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  cmd_busy_a: assert property (cmd_s |=> o_busy)
    else $error("command not taken");
  busy_cause_a: assert property ($rose(o_busy) |-> $past(i_wr && i_addr == ADDR_CMD))
    else $error("busy without command");
  upper_pair_a: assert property (o_upper_en |-> o_lower_en)
    else $error("upper converter alone");
  en_ref_a: assert property (o_lower_en |-> o_ref_on && o_busy)
    else $error("converter runs without reference");
  pwrup_wait_a: assert property ($rose(o_lower_en) |-> int'(up_cnt_r) >= REF_WAIT)
    else $error("conversion before reference settled");
  ready_fast_a: assert property (warm_cmd_s |-> ##[1:4] o_lower_en)
    else $error("warm start delayed");
  ref_hold_a: assert property (keep_r && o_ref_on && !o_busy && !i_wr |=> o_ref_on)
    else $error("reference dropped while kept on");
  end_state_a: assert property ($fell(o_busy) |-> ##[0:1] (o_ref_on == keep_r))
    else $error("wrong rest state after conversion");
endmodule

// ===== cam_conv_model.sv
`timescale 1ns/10ps
// --------------------------------
// converter front end model
// --------------------------------
module cam_conv_model (
  // clock
  input wire logic i_clk,
  // run enables and levels
  input wire logic i_lower_en,
  input wire logic i_upper_en,
  input wire logic [31:0] i_lower_val,
  input wire logic [31:0] i_upper_val,
  // samples
  output logic [31:0] o_lower_sample,
  output logic [31:0] o_upper_sample
);
  logic [31:0] churn_r = 32'h5A5A_A5A5;
  // a parked converter shows churn so a stale capture is caught
  always_ff @(posedge i_clk) begin
    churn_r <= {churn_r[30:0], ~churn_r[31]};
  end
  assign o_lower_sample = i_lower_en ? i_lower_val : churn_r;
  assign o_upper_sample = i_upper_en ? i_upper_val : ~churn_r;
endmodule

// ===== test_cell_adc_mode_control.sv
`timescale 1ns/10ps
// --------------------------------
// mode control bench
// --------------------------------
module test_cell_adc_mode_control;
  import cam_pkg::*;
  localparam int unsigned WAIT_CYC = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata, lo_smp, up_smp, rd_v;
  logic [31:0] lo_val = 32'h0;
  logic [31:0] up_val = 32'h0;
  logic o_busy, o_ref_on, o_lower_en, o_upper_en;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  // index is field * 2 + option bit
  cam_mode_t mode_tbl [8] = '{CAM_MODE_3K, CAM_MODE_14K, CAM_MODE_27K, CAM_MODE_14K,
    CAM_MODE_7K, CAM_MODE_3K, CAM_MODE_26, CAM_MODE_2K};
  cam_core #(.REF_WAIT(WAIT_CYC)) cam_core_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_lower_sample(lo_smp), .i_upper_sample(up_smp), .o_busy(o_busy),
    .o_ref_on(o_ref_on), .o_lower_en(o_lower_en), .o_upper_en(o_upper_en));
  cam_conv_model cam_conv_model_inst (.i_clk(i_clk), .i_lower_en(o_lower_en),
    .i_upper_en(o_upper_en), .i_lower_val(lo_val), .i_upper_val(up_val),
    .o_lower_sample(lo_smp), .o_upper_sample(up_smp));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rst();
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask
  // bounded waits, sampled 1 ns after the edge so updates have landed
  task automatic wait_en();
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (o_lower_en !== 1'b1 && n < 500);
  endtask
  task automatic wait_idle();
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (o_busy !== 1'b0 && n < 4000);
    chk("busy", {31'h0, o_busy}, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(30000 * 50);
    error_cnt++;
    summarize();
  end
  initial begin
    rst();
    rd(8'hFC);
    chk("unmapped", rd_v, 32'h0);
    // every option and field pairing, cut short by reset
    for (int i = 0; i < 8; i++) begin
      rst();
      wr(ADDR_CFG, {31'h0, i[0]});
      wr(ADDR_CMD, {29'h0, 1'b1, i[2:1]});
      rd(ADDR_STATUS);
      chk("mode", {29'h0, rd_v[6:4]}, {29'h0, mode_tbl[i]});
      chk("state", {29'h0, rd_v[3:1]}, {29'h0, CAM_ST_PWRUP});
    end
    // twelve cells, fast mode, upper reading below zero
    rst();
    lo_val <= 32'h0000_80E8;
    up_val <= 32'hFFFF_FFFB;
    wr(ADDR_CMD, 32'h1);
    wait_en();
    chk("cold start", {31'h0, n >= WAIT_CYC}, 32'h1);
    chk("upper en", {31'h0, o_upper_en}, 32'h1);
    wait_idle();
    chk("fast time", 32'(n), 32'(CELLS_PER_CONV * (OSR_27K + CAL_CYC)));
    chk("ref off", {31'h0, o_ref_on}, 32'h0);
    for (int k = 0; k < 12; k++) begin
      rd(ADDR_RESULT_BASE + 8'(4 * k));
      chk("cell", rd_v, (k < 6) ? 32'h80E8 : 32'h0);
    end
    // aux inputs with the reference kept on, reading past full scale
    lo_val <= 32'h0001_2345;
    wr(ADDR_CFG, 32'h4);
    wr(ADDR_CMD, 32'h5);
    wait_en();
    chk("aux upper", {31'h0, o_upper_en}, 32'h0);
    // a cell command while busy must be refused
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_CMD);
    chk("busy cmd", rd_v, 32'h5);
    wait_idle();
    chk("ref kept", {31'h0, o_ref_on}, 32'h1);
    for (int k = 12; k < 18; k++) begin
      rd(ADDR_RESULT_BASE + 8'(4 * k));
      chk("aux", rd_v, 32'h0000_FFFF);
    end
    // warm start skips the reference delay
    wr(ADDR_CMD, 32'h1);
    wait_en();
    chk("warm start", {31'h0, n < 5}, 32'h1);
    wait_idle();
    chk("ref ready", {31'h0, o_ref_on}, 32'h1);
    summarize();
  end
endmodule
bind cam_core cam_core_sva #(.REF_WAIT(REF_WAIT)) cam_core_sva_inst (.i_clk(i_clk),
  .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_busy(o_busy), .o_ref_on(o_ref_on), .o_lower_en(o_lower_en),
  .o_upper_en(o_upper_en));
